// ===== rtl/gp_map.svh
// Register indices, field positions, reset values and bus codes of the dual port block.
`ifndef GP_MAP_SVH
`define GP_MAP_SVH
`define GP_IDX_LO_DATA    8'h05
`define GP_IDX_HI_DATA    8'h06
`define GP_IDX_INTCTL     8'h0b
`define GP_IDX_OPTION     8'h81
`define GP_IDX_LO_DIR     8'h85
`define GP_IDX_HI_DIR     8'h86
`define GP_IDX_ANA        8'h9f
`define GP_BIT_PU_N       7
`define GP_BIT_GIE        7
`define GP_BIT_PCE        3
`define GP_BIT_PCF        0
`define GP_BIT_OD         4
`define GP_RST_OPTION     8'hff
`define GP_RST_LO_DIR     6'h3f
`define GP_RST_HI_DIR     8'hff
`define GP_RST_ANA        3'h0
`define GP_RST_INT_BIT    1'h0
`define GP_RESP_OKAY      2'h0
`define GP_RESP_SLVERR    2'h2
`endif

// ===== rtl/gp_pkg.sv
// Types shared by the dual port block: bus channel carriers and write states.
package gp_pkg;
    typedef struct packed {
        logic [11:0] awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [11:0] araddr;
        logic        arvalid;
        logic        rready;
    } gp_axi_req_s;
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } gp_axi_rsp_s;
    typedef enum logic [1:0] {
        GP_WR_ACC = 2'b01,
        GP_WR_RSP = 2'b10
    } gp_wr_e;
endpackage : gp_pkg

// ===== rtl/gp_top.sv
// Dual general purpose port with change detection behind an AXI4-Lite slave.
// Behaviour
// - Five-pin low port with direction bits.
// - Low direction one floats the pin.
// - Low direction zero drives latch value.
// - Reads return pins, writes load latch.
// - Writes merge into latch after pin read.
// - Low bit four is open-drain timer input.
// - Analog field picks analog low bits.
// - Reset leaves bits analog, reading zero.
// - Direction bits still rule analog pins.
// - Low direction resets ones, latch untouched.
// - Eight-pin high port, same direction coding.
// - Cleared pull-up bit enables all pull-ups.
// - Output pins lose their pull-up.
// - Reset leaves pull-ups off, option ones.
// - Peripheral may override high direction bits.
// - Change detect on input bits seven-four.
// - Mismatch against snapshot sets change flag.
// - Persisting mismatch keeps flag set; access refreshes.
// - Change flag wakes device from sleep.
// - High direction resets ones, latch untouched.
// - Flag sets regardless of enable bits.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "gp_map.svh"
module gp_top (
    input  wire  logic               aclk,            // Clock, 200 MHz.
    input  wire  logic               aresetn,         // Synchronous reset, low active.
    input  wire  gp_pkg::gp_axi_req_s axi_req,        // Bus request channels.
    output       gp_pkg::gp_axi_rsp_s axi_rsp,        // Bus response channels.
    input  wire  logic [4:0]         lo_pin_in,       // Low port pin levels.
    output       logic [4:0]         lo_pin_out,      // Low port drive values.
    output       logic [4:0]         lo_pin_oe,       // Low port drive enables.
    input  wire  logic [7:0]         hi_pin_in,       // High port pin levels.
    output       logic [7:0]         hi_pin_out,      // High port drive values.
    output       logic [7:0]         hi_pin_oe,       // High port drive enables.
    output       logic [7:0]         hi_pullup_en,    // Weak pull-up enables.
    input  wire  logic [7:0]         periph_ovr_en,   // Peripheral direction takeover.
    input  wire  logic [7:0]         periph_ovr_dir,  // Peripheral direction value.
    output       logic [3:0]         analog_sel,      // Low bits in analog use.
    output       logic               low_bit4_timer_clock, // Timer clock from low bit 4.
    output       logic               irq,             // Port change interrupt request.
    output       logic               wake             // Wake request from sleep.
);
    import gp_pkg::*;

    // True when a byte address is the aligned first byte of the word of a register index.
    function automatic logic gp_hit(input logic [11:0] addr, input logic [7:0] idx);
        gp_hit = (addr[11:2] == {2'h0, idx}) && (addr[1:0] == 2'h0);
    endfunction : gp_hit

    // True when a byte address names any register of the block.
    function automatic logic gp_mapped(input logic [11:0] addr);
        gp_mapped = gp_hit(addr, `GP_IDX_LO_DATA) || gp_hit(addr, `GP_IDX_HI_DATA) ||
                    gp_hit(addr, `GP_IDX_INTCTL) || gp_hit(addr, `GP_IDX_OPTION) ||
                    gp_hit(addr, `GP_IDX_LO_DIR) || gp_hit(addr, `GP_IDX_HI_DIR) ||
                    gp_hit(addr, `GP_IDX_ANA);
    endfunction : gp_mapped

    // Maps the analog select field to the set of low bits taken as analog.
    function automatic logic [3:0] gp_ana_mask(input logic [2:0] code);
        unique case (code)
            3'h0, 3'h1: gp_ana_mask = 4'hf;
            3'h2, 3'h3: gp_ana_mask = 4'h7;
            3'h4, 3'h5: gp_ana_mask = 4'h3;
            3'h6, 3'h7: gp_ana_mask = 4'h0;
        endcase
    endfunction : gp_ana_mask

    logic [4:0] lo_s1_ff;
    logic [4:0] lo_s2_ff;
    logic [7:0] hi_s1_ff;
    logic [7:0] hi_s2_ff;
    logic [4:0] lo_latch_ff;
    logic [7:0] hi_latch_ff;
    logic [5:0] lo_dir_ff;
    logic [7:0] hi_dir_ff;
    logic [7:0] option_ff;
    logic [2:0] ana_ff;
    logic       gie_ff;
    logic       pce_ff;
    logic       pcf_ff;
    logic [3:0] snap_ff;
    gp_wr_e     wr_st_ff;
    logic       aw_got_ff;
    logic       w_got_ff;
    logic [11:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic       awready_ff;
    logic       wready_ff;
    logic       bvalid_ff;
    logic [1:0] bresp_ff;
    logic       arready_ff;
    logic       rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic [4:0] lo_out_ff;
    logic [4:0] lo_oe_ff;
    logic [7:0] hi_out_ff;
    logic [7:0] hi_oe_ff;
    logic [7:0] pu_en_ff;
    logic [3:0] ana_sel_ff;
    logic       tclk_ff;
    logic       irq_ff;
    logic       wake_ff;
    logic        aw_hs;
    logic        w_hs;
    logic        have_aw;
    logic        have_w;
    logic        wr_go;
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        ar_hs;
    logic [7:0]  hi_dir_eff;
    logic [3:0]  ana_mask;
    logic [3:0]  mismatch;
    logic        pc_hit;
    logic [7:0]  rd_val;

    // Response channels come straight from their registers.
    assign axi_rsp = '{awready: awready_ff, wready: wready_ff, bvalid: bvalid_ff,
                       bresp: bresp_ff, arready: arready_ff, rvalid: rvalid_ff,
                       rdata: rdata_ff, rresp: rresp_ff};
    assign lo_pin_out           = lo_out_ff;
    assign lo_pin_oe            = lo_oe_ff;
    assign hi_pin_out           = hi_out_ff;
    assign hi_pin_oe            = hi_oe_ff;
    assign hi_pullup_en         = pu_en_ff;
    assign analog_sel           = ana_sel_ff;
    assign low_bit4_timer_clock = tclk_ff;
    assign irq                  = irq_ff;
    assign wake                 = wake_ff;

    // Handshakes and the write that fires once address and data are both in.
    assign aw_hs   = axi_req.awvalid && awready_ff;
    assign w_hs    = axi_req.wvalid && wready_ff;
    assign have_aw = aw_got_ff || aw_hs;
    assign have_w  = w_got_ff || w_hs;
    assign wr_go   = (wr_st_ff == GP_WR_ACC) && have_aw && have_w;
    assign wr_addr = aw_got_ff ? awaddr_ff : axi_req.awaddr;
    assign wr_data = w_got_ff ? wdata_ff : axi_req.wdata;
    assign wr_strb = w_got_ff ? wstrb_ff : axi_req.wstrb;
    assign ar_hs   = axi_req.arvalid && arready_ff;

    assign hi_dir_eff = (periph_ovr_en & periph_ovr_dir) | (~periph_ovr_en & hi_dir_ff);
    assign ana_mask   = gp_ana_mask(ana_ff);
    // Only input pins seven to four compare.
    assign mismatch   = (hi_s2_ff[7:4] ^ snap_ff) & hi_dir_eff[7:4];
    // Any read or write of the high port refreshes the snapshot.
    assign pc_hit     = (ar_hs && gp_hit(axi_req.araddr, `GP_IDX_HI_DATA)) ||
                        (wr_go && gp_hit(wr_addr, `GP_IDX_HI_DATA));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lo_s1_ff <= 5'h00;
            lo_s2_ff <= 5'h00;
            hi_s1_ff <= 8'h00;
            hi_s2_ff <= 8'h00;
        end else begin
            lo_s1_ff <= lo_pin_in;
            lo_s2_ff <= lo_s1_ff;
            hi_s1_ff <= hi_pin_in;
            hi_s2_ff <= hi_s1_ff;
        end
    end

    // Write channel control; address and data may arrive in either order.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_st_ff   <= GP_WR_ACC;
            aw_got_ff  <= 1'b0;
            w_got_ff   <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `GP_RESP_OKAY;
            awaddr_ff  <= 12'h000;
            wdata_ff   <= 32'h0000_0000;
            wstrb_ff   <= 4'h0;
        end else begin
            unique case (wr_st_ff)
                GP_WR_ACC: begin
                    if (aw_hs) begin
                        awaddr_ff <= axi_req.awaddr;
                    end
                    if (w_hs) begin
                        wdata_ff <= axi_req.wdata;
                        wstrb_ff <= axi_req.wstrb;
                    end
                    awready_ff <= !wr_go && !have_aw;
                    wready_ff  <= !wr_go && !have_w;
                    if (wr_go) begin
                        wr_st_ff  <= GP_WR_RSP;
                        aw_got_ff <= 1'b0;
                        w_got_ff  <= 1'b0;
                        bvalid_ff <= 1'b1;
                        bresp_ff  <= gp_mapped(wr_addr) ? `GP_RESP_OKAY : `GP_RESP_SLVERR;
                    end else begin
                        aw_got_ff <= have_aw;
                        w_got_ff  <= have_w;
                    end
                end
                GP_WR_RSP: begin
                    awready_ff <= axi_req.bready;
                    wready_ff  <= axi_req.bready;
                    if (axi_req.bready) begin
                        bvalid_ff <= 1'b0;
                        wr_st_ff  <= GP_WR_ACC;
                    end
                end
            endcase
        end
    end

    // Read value of the addressed register; unmapped words read zero.
    always_comb begin
        rd_val = 8'h00;
        if (gp_hit(axi_req.araddr, `GP_IDX_LO_DATA)) begin
            rd_val = {3'h0, lo_s2_ff[4], lo_s2_ff[3:0] & ~ana_mask};
        end
        if (gp_hit(axi_req.araddr, `GP_IDX_HI_DATA)) begin
            rd_val = hi_s2_ff;
        end
        if (gp_hit(axi_req.araddr, `GP_IDX_INTCTL)) begin
            rd_val = {gie_ff, 3'h0, pce_ff, 2'h0, pcf_ff};
        end
        if (gp_hit(axi_req.araddr, `GP_IDX_OPTION)) begin
            rd_val = option_ff;
        end
        if (gp_hit(axi_req.araddr, `GP_IDX_LO_DIR)) begin
            rd_val = {2'h0, lo_dir_ff};
        end
        if (gp_hit(axi_req.araddr, `GP_IDX_HI_DIR)) begin
            rd_val = hi_dir_ff;
        end
        if (gp_hit(axi_req.araddr, `GP_IDX_ANA)) begin
            rd_val = {5'h00, ana_ff};
        end
    end

    // Read channel: one read at a time, data one cycle after the address.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= `GP_RESP_OKAY;
        end else if (ar_hs) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b1;
            rdata_ff   <= {24'h00_0000, rd_val};
            rresp_ff   <= gp_mapped(axi_req.araddr) ? `GP_RESP_OKAY : `GP_RESP_SLVERR;
        end else if (rvalid_ff) begin
            arready_ff <= axi_req.rready;
            rvalid_ff  <= !axi_req.rready;
        end else begin
            arready_ff <= 1'b1;
        end
    end

    // Write merges into latch; an empty lane stores pins.
    // Latches keep their value across reset.
    always_ff @(posedge aclk) begin
        if (wr_go && gp_hit(wr_addr, `GP_IDX_LO_DATA)) begin
            lo_latch_ff <= wr_strb[0] ? wr_data[4:0] : lo_s2_ff;
        end
        if (wr_go && gp_hit(wr_addr, `GP_IDX_HI_DATA)) begin
            hi_latch_ff <= wr_strb[0] ? wr_data[7:0] : hi_s2_ff;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lo_dir_ff <= `GP_RST_LO_DIR;
            hi_dir_ff <= `GP_RST_HI_DIR;
            option_ff <= `GP_RST_OPTION;
            ana_ff    <= `GP_RST_ANA;
            gie_ff    <= `GP_RST_INT_BIT;
            pce_ff    <= `GP_RST_INT_BIT;
        end else if (wr_go && wr_strb[0]) begin
            if (gp_hit(wr_addr, `GP_IDX_LO_DIR)) begin
                lo_dir_ff <= wr_data[5:0];
            end
            if (gp_hit(wr_addr, `GP_IDX_HI_DIR)) begin
                hi_dir_ff <= wr_data[7:0];
            end
            if (gp_hit(wr_addr, `GP_IDX_OPTION)) begin
                option_ff <= wr_data[7:0];
            end
            if (gp_hit(wr_addr, `GP_IDX_ANA)) begin
                ana_ff <= wr_data[2:0];
            end
            if (gp_hit(wr_addr, `GP_IDX_INTCTL)) begin
                gie_ff <= wr_data[`GP_BIT_GIE];
                pce_ff <= wr_data[`GP_BIT_PCE];
            end
        end
    end
    // Snapshot refresh on high port access.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            snap_ff <= 4'h0;
        end else if (pc_hit) begin
            snap_ff <= hi_s2_ff[7:4];
        end
    end
    // Set ignores enables and wins over a clear.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pcf_ff <= `GP_RST_INT_BIT;
        end else if (|mismatch) begin
            pcf_ff <= 1'b1;
        end else if (wr_go && wr_strb[0] && gp_hit(wr_addr, `GP_IDX_INTCTL)) begin
            pcf_ff <= wr_data[`GP_BIT_PCF];
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lo_out_ff <= 5'h00;
            lo_oe_ff  <= 5'h00;
            hi_out_ff <= 8'h00;
            hi_oe_ff  <= 8'h00;
        end else begin
            lo_out_ff[3:0] <= lo_latch_ff[3:0] & ~lo_dir_ff[3:0];
            lo_oe_ff[3:0]  <= ~lo_dir_ff[3:0];
            lo_out_ff[`GP_BIT_OD] <= 1'b0;
            lo_oe_ff[`GP_BIT_OD]  <= !lo_dir_ff[`GP_BIT_OD] && !lo_latch_ff[`GP_BIT_OD];
            hi_out_ff <= hi_latch_ff & ~hi_dir_eff;
            hi_oe_ff  <= ~hi_dir_eff;
        end
    end
    // Pull-ups, analog select, timer clock, interrupt and wake outputs.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pu_en_ff   <= 8'h00;
            ana_sel_ff <= 4'hf;
            tclk_ff    <= 1'b0;
            irq_ff     <= 1'b0;
            wake_ff    <= 1'b0;
        end else begin
            pu_en_ff   <= option_ff[`GP_BIT_PU_N] ? 8'h00 : hi_dir_eff;
            ana_sel_ff <= ana_mask;
            tclk_ff    <= lo_s2_ff[`GP_BIT_OD];
            irq_ff     <= pcf_ff && pce_ff && gie_ff;
            wake_ff    <= pcf_ff;
        end
    end
    lo_float_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 (lo_oe_ff[3:0] == ~$past(lo_dir_ff[3:0]))) else $error("low enable off direction");
    lo_drive_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (lo_dir_ff[0] == 1'b0) ##1 (lo_dir_ff[0] == 1'b0) |-> lo_out_ff[0] == $past(lo_latch_ff[0]))
        else $error("low pin zero not driven from latch");
    od_bit4_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (lo_out_ff[4] == 1'b0) and (lo_oe_ff[4] |-> $past(!lo_latch_ff[4])))
        else $error("open-drain bit drives high");
    ana_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ar_hs && gp_hit(axi_req.araddr, `GP_IDX_LO_DATA) |=> (rdata_ff[3:0] & ana_sel_ff) == 4'h0)
        else $error("analog bit read non-zero");
    dir_reset_a: assert property (@(posedge aclk)
        $rose(aresetn) |-> lo_dir_ff == 6'h3f && hi_dir_ff == 8'hff && option_ff == 8'hff)
        else $error("direction or option not reset to ones");
    pullup_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 (pu_en_ff == ($past(option_ff[7]) ? 8'h00 : $past(hi_dir_eff))))
        else $error("pull-up enable wrong");
    flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (|mismatch) |=> pcf_ff ##1 wake_ff) else $error("change flag or wake missed");
    set_wins_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (|mismatch) && !pce_ff && wr_go && gp_hit(wr_addr, `GP_IDX_INTCTL) |=> pcf_ff)
        else $error("clear beat a pending change");
    snap_fresh_a: assert property (@(posedge aclk) disable iff (!aresetn)
        pc_hit |=> snap_ff == $past(hi_s2_ff[7:4])) else $error("snapshot not refreshed");
    irq_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 (irq_ff == ($past(pcf_ff) && $past(pce_ff) && $past(gie_ff))))
        else $error("interrupt request gating wrong");
endmodule : gp_top

// ===== verif/gp_pins.sv
// Pin-side model: outside circuitry sharing the two port pin groups.
`timescale 1ns/1ps
module gp_pins (
    input  wire logic       aclk,         // Clock used to vary floating lines.
    input  wire logic [4:0] lo_pin_out,   // Low port drive values.
    input  wire logic [4:0] lo_pin_oe,    // Low port drive enables.
    input  wire logic [7:0] hi_pin_out,   // High port drive values.
    input  wire logic [7:0] hi_pin_oe,    // High port drive enables.
    input  wire logic [7:0] hi_pullup_en, // Weak pull-up enables.
    input  wire logic [4:0] ext_lo,       // Outside drive on the low port.
    input  wire logic [7:0] ext_hi,       // Outside drive on the high port.
    input  wire logic [7:0] ext_hi_en,    // High pins that the outside drives.
    output      logic [4:0] lo_pin_in,    // Resolved low port levels.
    output      logic [7:0] hi_pin_in     // Resolved high port levels.
);
    logic [7:0] flt_ff = 8'h5a; // Changing pattern on a line nobody holds.

    // A released line without pull-up must not keep its last value.
    always_ff @(posedge aclk) begin
        flt_ff <= ~flt_ff;
    end

    // low port resolution, open drain bit four included
    // The outside always drives the low port where the block does not.
    assign lo_pin_in = (lo_pin_oe & lo_pin_out) | (~lo_pin_oe & ext_lo);

    // pull-up resolution
    // Driven, else outside driven, else pulled up or floating.
    assign hi_pin_in = (hi_pin_oe & hi_pin_out) | (~hi_pin_oe & ext_hi_en & ext_hi)
                     | (~hi_pin_oe & ~ext_hi_en & (hi_pullup_en | flt_ff));
endmodule : gp_pins

// ===== verif/tb_dual_io_port_with_change_irq.sv
// Self-checking bench for the dual port block with its pin-side model.
`timescale 1ns/1ps
`include "gp_map.svh"
module tb_dual_io_port_with_change_irq;
    import gp_pkg::*;
    localparam logic [7:0] ld = `GP_IDX_LO_DATA, hd = `GP_IDX_HI_DATA, ic = `GP_IDX_INTCTL;
    localparam logic [7:0] op = `GP_IDX_OPTION, ldr = `GP_IDX_LO_DIR, hdr = `GP_IDX_HI_DIR;
    localparam logic [7:0] an = `GP_IDX_ANA;
    logic        aclk, aresetn, t0clk, irq, wake;
    gp_axi_req_s req;
    gp_axi_rsp_s rsp;
    logic [4:0]  lo_in, lo_out, lo_oe, ext_lo;
    logic [7:0]  hi_in, hi_out, hi_oe, hi_pu, ovr_en, ovr_dir, ext_hi, ext_en, r;
    logic [3:0]  asel;
    logic [3:0]  am [4];
    logic [33:0] q [$];
    int          err_total, compares, cyc, i;

    gp_top dut (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
        .lo_pin_in(lo_in), .lo_pin_out(lo_out), .lo_pin_oe(lo_oe), .hi_pin_in(hi_in),
        .hi_pin_out(hi_out), .hi_pin_oe(hi_oe), .hi_pullup_en(hi_pu),
        .periph_ovr_en(ovr_en), .periph_ovr_dir(ovr_dir), .analog_sel(asel),
        .low_bit4_timer_clock(t0clk), .irq(irq), .wake(wake));
    gp_pins pins (.aclk(aclk), .lo_pin_out(lo_out), .lo_pin_oe(lo_oe), .hi_pin_out(hi_out),
        .hi_pin_oe(hi_oe), .hi_pullup_en(hi_pu), .ext_lo(ext_lo), .ext_hi(ext_hi),
        .ext_hi_en(ext_en), .lo_pin_in(lo_in), .hi_pin_in(hi_in));

    // Free-running 200 MHz clock.
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    task automatic fail(input string m);
        err_total++;
        $display("MISMATCH t=%0t %s", $time, m);
    endtask : fail

    task automatic chk_bus(input logic [33:0] g, input logic [33:0] e);
        compares++;
        if (g !== e) fail($sformatf("bus got %h exp %h", g, e));
    endtask : chk_bus

    task automatic chk_pin(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) fail($sformatf("pins got %h exp %h", g, e));
    endtask : chk_pin

    task automatic results();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : results

    // One bus transfer; channels are released at their own handshake edge.
    task automatic xf(input bit w, input logic [7:0] a, input logic [7:0] d,
                      input logic [3:0] s, input logic [33:0] e);
        bit ta, tw, tr, c;
        @(posedge aclk);
        q.push_back(e);
        req.awaddr <= {2'h0, a, 2'h0};
        req.araddr <= {2'h0, a, 2'h0};
        req.wdata <= {24'h0, d};
        req.wstrb <= s;
        {req.awvalid, req.wvalid, req.bready} <= {3{w}};
        {req.arvalid, req.rready} <= {2{!w}};
        c = 1'b0;
        for (int n = 0; n < 40 && !c; n++) begin
            @(negedge aclk);
            ta = req.awvalid && rsp.awready;
            tw = req.wvalid && rsp.wready;
            tr = req.arvalid && rsp.arready;
            c = (rsp.bvalid && req.bready) || (rsp.rvalid && req.rready);
            @(posedge aclk);
            if (ta) req.awvalid <= 1'b0;
            if (tw) req.wvalid <= 1'b0;
            if (tr) req.arvalid <= 1'b0;
            if (c) {req.bready, req.rready} <= 2'b00;
        end
        if (!c) fail("no bus response");
        repeat (2) @(negedge aclk);
    endtask : xf

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xf(1'b1, a, d, 4'hf, 34'h0);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] v);
        xf(1'b0, a, 8'h00, 4'hf, {26'h0, v});
    endtask : rd

    // Outside pin levels change at a rising edge, then settle through the synchroniser.
    task automatic set_ext(input logic [4:0] l, input logic [7:0] h, input logic [7:0] e,
                           input logic [7:0] o);
        @(posedge aclk);
        {ext_lo, ext_hi, ext_en, ovr_en, ovr_dir} <= {l, h, e, o, 8'hff};
        repeat (4) @(negedge aclk);
    endtask : set_ext

    // Each bus answer is compared with the oldest expectation.
    always @(negedge aclk) begin
        if ((rsp.bvalid && req.bready) || (rsp.rvalid && req.rready)) begin
            if (q.size() == 0) fail("unexpected response");
            else chk_bus(rsp.bvalid ? {rsp.bresp, 32'h0} : {rsp.rresp, rsp.rdata}, q.pop_front());
        end
    end

    // Cuts a hang short.
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 6000) begin
            fail("timeout");
            results();
        end
    end

    // Main sequence.
    initial begin
        void'($urandom(32'hee0e));
        r = 8'($urandom());
        aresetn = 1'b0;
        req = '0;
        {ext_lo, ext_hi, ext_en, ovr_en, ovr_dir} = {5'h1f, r, 8'hff, 16'h00ff};
        am = '{4'hf, 4'h7, 4'h3, 4'h0};
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd(op, 8'hff);
        rd(ldr, 8'h3f);
        rd(hdr, 8'hff);
        rd(an, 8'h00);
        rd(ld, 8'h10);
        rd(hd, r);
        chk_pin({lo_oe, hi_oe[2:0]}, 8'h00);
        chk_pin(hi_pu, 8'h00);
        xf(1'b0, 8'h40, 8'h00, 4'hf, {2'h2, 32'h0});
        xf(1'b1, 8'h41, 8'h55, 4'hf, {2'h2, 32'h0});
        $display("test reset_and_map done");
        wr(an, 8'h06);
        wr(ld, 8'h0a);
        wr(ldr, 8'h00);
        chk_pin({lo_oe, lo_out[2:0]}, 8'hfa);
        chk_pin({3'h0, lo_out}, 8'h0a);
        rd(ld, 8'h0a);
        wr(ld, 8'h1a);
        chk_pin({3'h0, lo_oe}, 8'h0f);
        rd(ld, 8'h1a);
        chk_pin({7'h0, t0clk}, 8'h01);
        set_ext(5'h0f, r, 8'hff, 8'h00);
        rd(ld, 8'h0a);
        chk_pin({7'h0, t0clk}, 8'h00);
        wr(ldr, 8'h3f);
        $display("test low_drive done");
        xf(1'b1, hd, 8'h00, 4'h0, 34'h0);
        wr(hdr, 8'h00);
        chk_pin(hi_out, r);
        chk_pin(hi_oe, 8'hff);
        $display("test merge_write done");
        set_ext(5'h1f, r, 8'hff, 8'h00);
        for (i = 0; i < 8; i++) begin
            wr(an, 8'(i));
            chk_pin({4'h0, asel}, {4'h0, am[i/2]});
            rd(ld, {4'h1, ~am[i/2]});
        end
        $display("test analog_select done");
        wr(hdr, 8'hf0);
        wr(op, 8'h7f);
        chk_pin(hi_pu, 8'hf0);
        set_ext(5'h1f, r, 8'h00, 8'h01);
        chk_pin(hi_pu, 8'hf1);
        chk_pin(hi_oe, 8'h0e);
        rd(hd, {4'hf, r[3:1], 1'b1});
        wr(op, 8'hff);
        chk_pin(hi_pu, 8'h00);
        $display("test pullups done");
        wr(hdr, 8'h7f);
        set_ext(5'h1f, 8'h00, 8'hff, 8'h00);
        rd(hd, {r[7], 7'h00});
        wr(ic, 8'h00);
        set_ext(5'h1f, 8'h8f, 8'hff, 8'h00);
        rd(ic, 8'h00);
        set_ext(5'h1f, 8'h2f, 8'hff, 8'h00);
        rd(ic, 8'h01);
        chk_pin({6'h0, irq, wake}, 8'h01);
        wr(ic, 8'h88);
        rd(ic, 8'h89);
        chk_pin({7'h0, irq}, 8'h01);
        rd(hd, {r[7], 7'h2f});
        wr(ic, 8'h88);
        rd(ic, 8'h88);
        chk_pin({6'h0, irq, wake}, 8'h00);
        $display("test change_detect done");
        wr(ldr, 8'h00);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ldr, 8'h3f);
        rd(hdr, 8'hff);
        wr(ldr, 8'h00);
        chk_pin({3'h0, lo_oe}, 8'h0f);
        wr(hdr, 8'h00);
        chk_pin(hi_out, r);
        wr(ldr, 8'h3f);
        $display("test second_reset done");
        results();
    end
endmodule : tb_dual_io_port_with_change_irq
